// file: rtl/tweep_pkg.sv
// constants, state codes and timing of the two-wire eeprom slave
// assumes a single 40 MHz system clock; bus pins arrive unsynchronised

package tweep_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int WRITE_CYCLE_TIME_MS = 10;
   // longest time, so round down
   localparam int WRITE_CYCLE_CYCLES = WRITE_CYCLE_TIME_MS * (CLK_HZ / 1000);
   localparam int ADDR_BITS = 13;
   localparam int PAGE_BITS = 5;
   localparam logic [3:0] DEV_ID = 4'hA;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_DONE = 4'h9;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DEVADDR = 3'b001,
      ST_ADDRHI = 3'b010,
      ST_ADDRLO = 3'b011,
      ST_WRDATA = 3'b100,
      ST_RDDATA = 3'b101,
      ST_IGNORE = 3'b110
   } tweep_state_t;
endpackage : tweep_pkg

// file: rtl/tweep_slave.sv
// two-wire serial eeprom slave with its own byte array
// assumes scl, sda and the straps are asynchronous pins; sda is open drain

`timescale 1ns/1ps
`default_nettype none

module tweep_slave #(
   parameter int ADDR_W = tweep_pkg::ADDR_BITS,
   parameter logic [19:0] WRITE_CYCLES = 20'(tweep_pkg::WRITE_CYCLE_CYCLES)
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe_n,
   input wire logic [2:0] device_select_pins,
   input wire logic write_protect_pin,
   output logic writeBusy,
   output logic standby
);
   // ***************************************************************
   // pin synchronisers and edge detection
   // ***************************************************************
   logic sclMeta, sclS, sclD, sdaMeta, sdaS, sdaD, wpMeta, wpS;
   logic [2:0] selMeta, selS;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sclMeta <= 1'b1;
         sclS <= 1'b1;
         sclD <= 1'b1;
         sdaMeta <= 1'b1;
         sdaS <= 1'b1;
         sdaD <= 1'b1;
         wpMeta <= 1'b0;
         wpS <= 1'b0;
         selMeta <= 3'h0;
         selS <= 3'h0;
      end else begin
         sclMeta <= sclIn;
         sclS <= sclMeta;
         sclD <= sclS;
         sdaMeta <= sdaIn;
         sdaS <= sdaMeta;
         sdaD <= sdaS;
         wpMeta <= write_protect_pin;
         wpS <= wpMeta;
         selMeta <= device_select_pins;
         selS <= selMeta;
      end
   end

   wire sclRise = sclS & ~sclD;
   wire sclFall = ~sclS & sclD;
   // sda edges under a high scl are framing, not data
   wire startCond = sclS & sclD & sdaD & ~sdaS;
   wire stopCond = sclS & sclD & ~sdaD & sdaS;

   // ***************************************************************
   // state and storage
   // ***************************************************************
   tweep_pkg::tweep_state_t state;
   logic [3:0] bitCnt;
   logic [7:0] rxShift, txShift, addrHi;
   logic [ADDR_W-1:0] addrCounter;
   logic masterAck, wroteAny, readMode;
   logic [19:0] busyCnt;
   logic [7:0] mem [0:(1 << ADDR_W)-1];

   function automatic logic [ADDR_W-1:0] pageInc(input logic [ADDR_W-1:0] a);
      pageInc = {a[ADDR_W-1:tweep_pkg::PAGE_BITS],
                 a[tweep_pkg::PAGE_BITS-1:0] + 5'h01};
   endfunction : pageInc

   wire busy = (busyCnt != 20'h0);
   wire wordDone = sclFall & (bitCnt == tweep_pkg::BIT_ACK);
   wire ackDone = sclFall & (bitCnt == tweep_pkg::BIT_DONE);
   // straps left open are pulled low at the pad, so selS reads zero
   wire devMatch = (rxShift[7:4] == tweep_pkg::DEV_ID)
                   & (rxShift[3:1] == selS);
   wire devAccept = devMatch & ~busy;
   wire upperQuarter = (addrCounter[ADDR_W-1 -: 2] == 2'b11);
   wire protect = wpS & upperQuarter;
   wire memWe = wordDone & (state == tweep_pkg::ST_WRDATA) & ~protect;
   wire [7:0] memRd = mem[addrCounter];
   wire readOn = (state == tweep_pkg::ST_RDDATA);

   // ***************************************************************
   // array write port
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (memWe) begin
         mem[addrCounter] <= rxShift;
      end
   end

   // ***************************************************************
   // timed write cycle
   // ***************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         busyCnt <= 20'h0;
      end else if (stopCond & wroteAny & ~busy) begin
         busyCnt <= WRITE_CYCLES;
      end else if (busy) begin
         busyCnt <= busyCnt - 20'h1;
      end
   end

   // ***************************************************************
   // protocol engine
   // ***************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= tweep_pkg::ST_IDLE;
         bitCnt <= 4'h0;
         rxShift <= 8'h00;
         txShift <= 8'hFF;
         addrHi <= 8'h00;
         addrCounter <= '0;
         masterAck <= 1'b0;
         wroteAny <= 1'b0;
         readMode <= 1'b0;
         sdaOe_n <= 1'b1;
      end else if (startCond) begin
         // repeated start also lands here, keeping the counter
         state <= tweep_pkg::ST_DEVADDR;
         bitCnt <= 4'h0;
         sdaOe_n <= 1'b1;
         wroteAny <= 1'b0;
      end else if (stopCond) begin
         state <= tweep_pkg::ST_IDLE;
         bitCnt <= 4'h0;
         sdaOe_n <= 1'b1;
         wroteAny <= 1'b0;
      end else if (state != tweep_pkg::ST_IDLE && state != tweep_pkg::ST_IGNORE) begin
         if (sclRise) begin
            if (bitCnt < tweep_pkg::BIT_ACK) begin
               rxShift <= {rxShift[6:0], sdaS};
            end else if (bitCnt == tweep_pkg::BIT_DONE) begin
               // ninth rise carries the controller's ack after a read byte
               masterAck <= ~sdaS;
            end
            if (bitCnt != tweep_pkg::BIT_DONE) begin
               bitCnt <= bitCnt + 4'h1;
            end
         end else if (wordDone) begin
            bitCnt <= tweep_pkg::BIT_DONE;
            unique case (state)
               tweep_pkg::ST_DEVADDR: begin
                  if (devAccept) begin
                     sdaOe_n <= 1'b0;
                     readMode <= rxShift[0];
                  end else begin
                     state <= tweep_pkg::ST_IGNORE;
                  end
               end
               tweep_pkg::ST_ADDRHI: begin
                  addrHi <= rxShift;
                  sdaOe_n <= 1'b0;
               end
               tweep_pkg::ST_ADDRLO: begin
                  addrCounter <= ADDR_W'({addrHi, rxShift});
                  sdaOe_n <= 1'b0;
               end
               tweep_pkg::ST_WRDATA: begin
                  addrCounter <= pageInc(addrCounter);
                  wroteAny <= 1'b1;
                  sdaOe_n <= 1'b0;
               end
               default: begin
                  // read byte out; controller owns the ninth bit
                  sdaOe_n <= 1'b1;
               end
            endcase
         end else if (ackDone) begin
            bitCnt <= 4'h0;
            sdaOe_n <= 1'b1;
            unique case (state)
               tweep_pkg::ST_DEVADDR: begin
                  if (readMode) begin
                     state <= tweep_pkg::ST_RDDATA;
                     sdaOe_n <= memRd[7];
                     txShift <= {memRd[6:0], 1'b1};
                     addrCounter <= addrCounter + ADDR_W'(1);
                  end else begin
                     state <= tweep_pkg::ST_ADDRHI;
                  end
               end
               tweep_pkg::ST_ADDRHI: state <= tweep_pkg::ST_ADDRLO;
               tweep_pkg::ST_ADDRLO: state <= tweep_pkg::ST_WRDATA;
               tweep_pkg::ST_WRDATA: state <= tweep_pkg::ST_WRDATA;
               default: begin
                  if (masterAck) begin
                     sdaOe_n <= memRd[7];
                     txShift <= {memRd[6:0], 1'b1};
                     addrCounter <= addrCounter + ADDR_W'(1);
                  end else begin
                     // nack: let go and wait for the stop
                     state <= tweep_pkg::ST_IGNORE;
                  end
               end
            endcase
         end else if (sclFall & readOn & (bitCnt < tweep_pkg::BIT_ACK)) begin
            // next data bit only ever moves while scl is low
            sdaOe_n <= txShift[7];
            txShift <= {txShift[6:0], 1'b1};
         end
      end
   end

   // ***************************************************************
   // registered status outputs
   // ***************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sdaOut <= 1'b0;
         writeBusy <= 1'b0;
         standby <= 1'b1;
      end else begin
         sdaOut <= 1'b0;
         writeBusy <= busy;
         standby <= ~busy & (state == tweep_pkg::ST_IDLE
                             || state == tweep_pkg::ST_IGNORE);
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   AST_START_GOES_ADDR: assert property (@(posedge clk) disable iff (reset)
      startCond |=> state == tweep_pkg::ST_DEVADDR && sdaOe_n)
      else $error("start did not open device address phase");
   AST_STOP_GOES_IDLE: assert property (@(posedge clk) disable iff (reset)
      stopCond |=> state == tweep_pkg::ST_IDLE && sdaOe_n)
      else $error("stop did not return to idle");
   AST_DRIVE_ONLY_SCL_LOW: assert property (@(posedge clk) disable iff (reset)
      $fell(sdaOe_n) |-> !$past(sclS))
      else $error("sda driven while scl high");
   AST_ADDR_BYTE_ACK: assert property (@(posedge clk) disable iff (reset)
      wordDone && !startCond && !stopCond && state == tweep_pkg::ST_ADDRHI
      |=> !sdaOe_n ##0 bitCnt == tweep_pkg::BIT_DONE)
      else $error("address byte not acknowledged");
   AST_BAD_ID_NO_ACK: assert property (@(posedge clk) disable iff (reset)
      wordDone && !stopCond && !startCond && state == tweep_pkg::ST_DEVADDR
      && rxShift[7:4] != tweep_pkg::DEV_ID |=> sdaOe_n && state == tweep_pkg::ST_IGNORE)
      else $error("wrong identifier acknowledged");
   AST_PIN_MISMATCH: assert property (@(posedge clk) disable iff (reset)
      wordDone && !stopCond && !startCond && state == tweep_pkg::ST_DEVADDR
      && rxShift[3:1] != selS |=> state == tweep_pkg::ST_IGNORE)
      else $error("select pin mismatch not ignored");
   AST_POLL_BUSY_NACK: assert property (@(posedge clk) disable iff (reset)
      busy && wordDone && state == tweep_pkg::ST_DEVADDR |=> sdaOe_n [*2])
      else $error("acknowledged while write cycle running");
   AST_PROTECT_BLOCKS: assert property (@(posedge clk) disable iff (reset)
      wpS && upperQuarter && wordDone |-> !memWe)
      else $error("protected quarter written");
   AST_PAGE_WRAP: assert property (@(posedge clk) disable iff (reset)
      memWe && !startCond && !stopCond |=> addrCounter[ADDR_W-1:5] == $past(addrCounter[ADDR_W-1:5])
      && addrCounter[4:0] == $past(addrCounter[4:0]) + 5'h01)
      else $error("page address did not wrap in page");
   AST_WRITE_CYCLE: assert property (@(posedge clk) disable iff (reset)
      stopCond && wroteAny && !busy |=> busyCnt == WRITE_CYCLES ##1 writeBusy)
      else $error("stop after write did not start write cycle");
   // read side: the controller's ack is taken on the ninth rise of scl
   AST_DATA_HOLD_SCL_HIGH: assert property (@(posedge clk) disable iff (reset)
      sclS && sclD |-> $stable(sdaOe_n))
      else $error("device sda moved while scl high");
   AST_DEV_ACK: assert property (@(posedge clk) disable iff (reset)
      wordDone && state == tweep_pkg::ST_DEVADDR && devMatch && !busy
      |=> !sdaOe_n && readMode == $past(rxShift[0]))
      else $error("matching device address not acknowledged");
   AST_CURRENT_READ: assert property (@(posedge clk) disable iff (reset)
      ackDone && state == tweep_pkg::ST_DEVADDR && readMode
      |=> readOn && sdaOe_n == $past(memRd[7])
      && addrCounter == $past(addrCounter) + ADDR_W'(1))
      else $error("current read did not start at counter");
   AST_READ_ACK_SAMPLED: assert property (@(posedge clk) disable iff (reset)
      sclRise && readOn && bitCnt == tweep_pkg::BIT_DONE |=> masterAck == !$past(sdaS))
      else $error("controller acknowledge not taken");
   AST_SEQ_READ_NEXT: assert property (@(posedge clk) disable iff (reset)
      ackDone && readOn && masterAck
      |=> readOn && sdaOe_n == $past(memRd[7])
      && addrCounter == $past(addrCounter) + ADDR_W'(1))
      else $error("sequential read did not move on");
   AST_NACK_RELEASES: assert property (@(posedge clk) disable iff (reset)
      ackDone && readOn && !masterAck |=> sdaOe_n && state == tweep_pkg::ST_IGNORE)
      else $error("bus not released after controller nack");
   AST_BUSY_NOT_STANDBY: assert property (@(posedge clk) disable iff (reset)
      writeBusy |-> !standby)
      else $error("standby shown during write cycle");

   COV_BYTE_WRITE: cover property (@(posedge clk) disable iff (reset)
      memWe ##[1:1000] stopCond);
   COV_SEQ_READ: cover property (@(posedge clk) disable iff (reset)
      ackDone && readOn && masterAck);
   COV_POLL_NACK: cover property (@(posedge clk) disable iff (reset)
      busy && wordDone && state == tweep_pkg::ST_DEVADDR && devMatch);
   COV_CURRENT_READ: cover property (@(posedge clk) disable iff (reset)
      ackDone && state == tweep_pkg::ST_DEVADDR && readMode);
   COV_PROTECT_DROP: cover property (@(posedge clk) disable iff (reset)
      wordDone && state == tweep_pkg::ST_WRDATA && protect);
endmodule : tweep_slave

`default_nettype wire

// file: dv/tweep_bus_master.sv
// behavioural two-wire bus controller facing the eeprom slave
// assumes the bench resolves sda from both pull-downs and a pull-up
`timescale 1ns/1ps
`default_nettype none
module tweep_bus_master (
   input wire logic clk,
   input wire logic sdaWire,
   output logic scl,
   output logic sdaPull
);
   // ******
   // bus phases: 4 clk low, 4 clk high per bit
   // ******
   initial begin
      scl = 1'b1;
      sdaPull = 1'b0;
   end
   task automatic waitClk(input int n);
      repeat (n) @(posedge clk);
   endtask : waitClk
   // sda moves 2 clk into the low phase so pin skew never fakes a start
   task automatic busBit(input logic b, output logic r);
      waitClk(2);
      sdaPull <= ~b;
      waitClk(2);
      scl <= 1'b1;
      waitClk(3);
      r = sdaWire;
      waitClk(1);
      scl <= 1'b0;
   endtask : busBit
   task automatic busStart();
      waitClk(2);
      sdaPull <= 1'b0;
      waitClk(2);
      scl <= 1'b1;
      waitClk(4);
      sdaPull <= 1'b1;
      waitClk(4);
      scl <= 1'b0;
   endtask : busStart
   task automatic busStop();
      waitClk(2);
      sdaPull <= 1'b1;
      waitClk(2);
      scl <= 1'b1;
      waitClk(4);
      sdaPull <= 1'b0;
      waitClk(4);
   endtask : busStop
   task automatic busRecover();
      logic r;
      for (int i = 0; i < 9; i++) begin
         busBit(1'b1, r);
         if (r) break;
      end
   endtask : busRecover
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) busBit(d[i], r);
      busBit(1'b1, r);
      ack = ~r;
   endtask : sendByte
   task automatic getByte(output logic [7:0] d, input logic more);
      logic r;
      for (int i = 7; i >= 0; i--) busBit(1'b1, d[i]);
      busBit(~more, r);
   endtask : getByte
endmodule : tweep_bus_master
`default_nettype wire

// file: dv/tb.sv
// self-checking bench for the two-wire eeprom slave
// assumes a short write cycle parameter and a pull-up on sda
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [2:0] pins = 3'h5;
   logic wp = 1'b0;
   logic scl, sdaPull, sdaOut, sdaOe_n, writeBusy, standby, sdaWire, ack;
   logic [7:0] expMem [0:8191];
   logic [7:0] d;
   int failCount = 0;
   int testsRun = 0;
   // ******
   // harness
   // ******
   always #12.5 clk = ~clk;
   assign sdaWire = (~sdaOe_n | sdaPull) ? 1'b0 : 1'b1;
   tweep_slave #(.WRITE_CYCLES(20'h000C8)) uut (.clk(clk), .reset(reset), .sclIn(scl),
      .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .device_select_pins(pins),
      .write_protect_pin(wp), .writeBusy(writeBusy), .standby(standby));
   tweep_bus_master busCtl (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaPull(sdaPull));
   task automatic completeRun();
      $display("checks %0d mismatches %0d", testsRun, failCount);
      if (failCount == 0 && testsRun > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : completeRun
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      testsRun++;
      if (seen !== want) begin
         failCount++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic waitBusy(input logic lvl, input int lim);
      int n;
      for (n = 0; n < lim && writeBusy !== lvl; n++) @(posedge clk);
      if (n == lim) begin
         check(writeBusy, lvl);
         completeRun();
      end
   endtask : waitBusy
   task automatic setAddr(input logic [12:0] a);
      busCtl.busStart();
      busCtl.sendByte({4'hA, pins, 1'b0}, ack);
      check(ack, 1);
      busCtl.sendByte({3'h0, a[12:8]}, ack);
      check(ack, 1);
      busCtl.sendByte(a[7:0], ack);
      check(ack, 1);
   endtask : setAddr
   task automatic wrSeq(input logic [12:0] a, input int n, input logic [7:0] d0);
      logic [4:0] lo;
      setAddr(a);
      for (int k = 0; k < n; k++) begin
         busCtl.sendByte(8'(d0 + k), ack);
         check(ack, 1);
         lo = 5'(a[4:0] + k);
         if (!(wp && a[12:11] == 2'h3)) expMem[{a[12:5], lo}] = 8'(d0 + k);
      end
      busCtl.busStop();
      waitBusy(1'b1, 20);
      check(standby, 0);
      busCtl.busStart();
      busCtl.sendByte({4'hA, pins, 1'b1}, ack);
      check(ack, 0);
      busCtl.busStop();
      waitBusy(1'b0, 400);
      busCtl.waitClk(4);
      check(standby, 1);
   endtask : wrSeq
   task automatic rdSeq(input logic [12:0] a, input int n);
      setAddr(a);
      busCtl.busStart();
      busCtl.sendByte({4'hA, pins, 1'b1}, ack);
      check(ack, 1);
      for (int k = 0; k < n; k++) begin
         busCtl.getByte(d, k < n - 1);
         check(d, expMem[13'(a + k)]);
      end
      busCtl.busStop();
      busCtl.waitClk(4);
      check({writeBusy, standby}, 2'h1);
   endtask : rdSeq
   // ******
   // scenarios
   // ******
   task automatic testPage();
      wrSeq(13'h005E, 34, 8'h40);
      rdSeq(13'h0040, 31);
      busCtl.busStart();
      busCtl.sendByte({4'hA, pins, 1'b1}, ack);
      check(ack, 1);
      busCtl.getByte(d, 1'b0);
      check(d, expMem[13'h005F]);
      busCtl.busStop();
      $display("page write wrap and reads done");
   endtask : testPage
   task automatic testWrap();
      wrSeq(13'h1FFF, 1, 8'h5A);
      wrSeq(13'h0000, 1, 8'hA5);
      rdSeq(13'h1FFF, 2);
      $display("array wrap done");
   endtask : testWrap
   task automatic testProtect();
      wp <= 1'b1;
      wrSeq(13'h1FFF, 1, 8'h33);
      wrSeq(13'h17FF, 1, 8'h77);
      rdSeq(13'h1FFF, 2);
      rdSeq(13'h17FF, 1);
      wp <= 1'b0;
      $display("write protect done");
   endtask : testProtect
   task automatic testMismatch();
      logic [7:0] bad [3];
      bad = '{{4'hB, pins, 1'b0}, {4'hA, pins ^ 3'h1, 1'b0}, {4'h2, pins, 1'b1}};
      foreach (bad[i]) begin
         busCtl.busStart();
         busCtl.sendByte(bad[i], ack);
         check(ack, 0);
         busCtl.busStop();
         check(standby, 1);
      end
      pins <= 3'h0;
      rdSeq(13'h0000, 1);
      $display("address match done");
   endtask : testMismatch
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      check({sdaOe_n, writeBusy, standby, sdaOut}, 4'hA);
      busCtl.busRecover();
      testPage();
      testWrap();
      testProtect();
      testMismatch();
      completeRun();
   end
endmodule : tb
`default_nettype wire
